// ### hw/tec_event_ctrl.sv
module tec_event_ctrl
  import tec_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // Register port
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic        REG_WR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_RD_I,
  output      logic [7:0]  REG_RDATA_O,
  // Sensing front end, same clock
  input  wire logic        SLEEP_I,
  input  wire logic [tec_pkg::NUM_BTN-1:0]  BTN_TOUCH_I,
  input  wire logic [tec_pkg::NUM_GRP-1:0]  GRP_TOUCH_I,
  input  wire logic [3:0]  GRP_EVENT_I,
  input  wire logic [tec_pkg::NUM_GPIO-1:0] GPIO_SET_I,
  input  wire logic [tec_pkg::NUM_LID-1:0]  LID_STATUS_I,
  input  wire logic [tec_pkg::NUM_LID-1:0]  LID_PATTERN_I,
  input  wire logic [tec_pkg::NUM_LID-1:0]  NOISE_I,
  // Host status clear
  input  wire logic        STATUS_CLR_I,
  // Status and events
  output      logic        ALERT_O,
  output      logic [7:0]  SAMPLE_MASK_O,
  output      logic [6:0]  BTN_ACCEPT_O,
  output      logic [6:0]  BTN_STATUS_O,
  output      logic [3:0]  GRP_STATUS_O,
  output      logic [7:0]  GPIO_STATUS_O,
  output      logic        BTN_MULTI_O,
  output      logic        GRP_MULTI_O,
  output      logic        LID_EVENT_O,
  output      logic [13:0] LID_NOISE_O,
  output      logic [7:0]  NEW_SLEEP_CH_O
);
  import tec_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]  touch_en;
    logic [7:0]  gpio_en;
    logic [7:0]  sleep_sel;
    logic [7:0]  mt_cfg;
    logic [7:0]  lid_cfg;
    logic [6:0]  accepted;
    logic [6:0]  btn_stat;
    logic [3:0]  grp_stat;
    logic [7:0]  gpio_stat;
    logic        lid_stat;
    logic        btn_multi;
    logic        grp_multi;
    logic [13:0] lid_noise;
    logic        irq;
    logic [7:0]  rd_data;
    logic [7:0]  new_sleep;
  } tec_state_t;

  localparam tec_state_t STATE_RST = '{
    touch_en:  RST_TOUCH_EN,
    gpio_en:   RST_GPIO_EN,
    sleep_sel: RST_SLEEP_SEL,
    mt_cfg:    RST_MT_CFG,
    lid_cfg:   RST_LID_CFG,
    default:   '0
  };

  tec_state_t s_q;
  tec_state_t s_d;

  logic [6:0] btn_eff;
  logic [6:0] grp_eff;
  logic [3:0] grp_evt;
  logic       grp_on;
  logic [2:0] btn_lim;
  logic [2:0] grp_lim;
  logic [2:0] acc_cnt;
  logic [6:0] acc;
  logic       lid_en;
  logic       lid_set;

  // Lid pattern comparator
  tec_lid_if lid_bus ();

  assign lid_bus.lid_status  = LID_STATUS_I;
  assign lid_bus.pattern     = LID_PATTERN_I;
  assign lid_bus.exact_match = s_q.lid_cfg[EXACT_BIT];

  tec_lid_cmp u_lid (
    .lid (lid_bus)
  );

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Sleep narrows sampling to the selected sensors
    btn_eff = SLEEP_I ? (BTN_TOUCH_I & s_q.sleep_sel[6:0])
                      : BTN_TOUCH_I;
    grp_on  = !SLEEP_I || s_q.sleep_sel[GRP_SLEEP_BIT];
    grp_eff = grp_on ? GRP_TOUCH_I : 7'h00;
    grp_evt = grp_on ? GRP_EVENT_I : 4'h0;
    btn_lim = tec_btn_limit(s_q.mt_cfg[BTN_LIM_LSB+:2]);
    grp_lim = tec_grp_limit(s_q.mt_cfg[GRP_LIM_LSB+:2]);

    // Keep held sensors first, then admit new ones from sensor 1 up.
    // Held sensors are still trimmed to the limit so a lowered limit
    // takes effect at once.
    acc     = 7'h00;
    acc_cnt = 3'h0;
    for (int i = 0; i < NUM_BTN; i++) begin
      if (s_q.accepted[i] && btn_eff[i] && acc_cnt < btn_lim) begin
        acc[i]  = 1'b1;
        acc_cnt = acc_cnt + 3'h1;
      end
    end
    for (int i = 0; i < NUM_BTN; i++) begin
      if (btn_eff[i] && !acc[i] && acc_cnt < btn_lim) begin
        acc[i]  = 1'b1;
        acc_cnt = acc_cnt + 3'h1;
      end
    end
    if (!s_q.mt_cfg[BLOCK_EN_BIT]) begin
      acc = btn_eff;
    end
    s_d.accepted = acc;

    // Multi-touch flags follow the raw counts
    s_d.btn_multi = tec_count7(btn_eff) > btn_lim;
    s_d.grp_multi = tec_count7(grp_eff) > grp_lim;

    // Lid detection and its noise association
    lid_en        = s_q.lid_cfg[LID_EN_BIT];
    lid_set       = lid_en && lid_bus.hit;
    s_d.lid_noise = lid_en ? NOISE_I : 14'h0000;

    // Sticky status: a set in the clear cycle wins
    s_d.btn_stat  = (STATUS_CLR_I ? 7'h00 : s_q.btn_stat) | acc;
    s_d.grp_stat  = (STATUS_CLR_I ? 4'h0 : s_q.grp_stat) | grp_evt;
    s_d.gpio_stat = (STATUS_CLR_I ? 8'h00 : s_q.gpio_stat) | GPIO_SET_I;
    s_d.lid_stat  = (!STATUS_CLR_I && s_q.lid_stat) || lid_set;

    // Alert from the next status so it rises with the status bit
    s_d.irq = (|(s_d.btn_stat & s_q.touch_en[6:0])) ||
              ((|s_d.grp_stat) && s_q.touch_en[GRP_IRQ_BIT]) ||
              (|(s_d.gpio_stat & s_q.gpio_en)) ||
              (s_d.lid_stat && s_q.lid_cfg[LID_IRQ_BIT]);

    // Register writes; newly enabled sleep channels flagged in Sleep
    s_d.new_sleep = 8'h00;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        OFS_TOUCH_EN:  s_d.touch_en = REG_WDATA_I;
        OFS_GPIO_EN:   s_d.gpio_en  = REG_WDATA_I;
        OFS_SLEEP_SEL: begin
          s_d.sleep_sel = REG_WDATA_I;
          if (SLEEP_I) begin
            s_d.new_sleep = REG_WDATA_I & ~s_q.sleep_sel;
          end
        end
        OFS_MT_CFG:    s_d.mt_cfg  = REG_WDATA_I & MT_WMASK;
        OFS_LID_CFG:   s_d.lid_cfg = REG_WDATA_I & LID_WMASK;
        default:       ;
      endcase
    end

    // Register reads; unmapped addresses return zero
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        OFS_TOUCH_EN:  s_d.rd_data = s_q.touch_en;
        OFS_GPIO_EN:   s_d.rd_data = s_q.gpio_en;
        OFS_SLEEP_SEL: s_d.rd_data = s_q.sleep_sel;
        OFS_MT_CFG:    s_d.rd_data = s_q.mt_cfg;
        OFS_LID_CFG:   s_d.rd_data = s_q.lid_cfg;
        default:       s_d.rd_data = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs, all from flip-flops
  assign REG_RDATA_O    = s_q.rd_data;
  assign ALERT_O        = s_q.irq;
  assign SAMPLE_MASK_O  = s_q.sleep_sel;
  assign BTN_ACCEPT_O   = s_q.accepted;
  assign BTN_STATUS_O   = s_q.btn_stat;
  assign GRP_STATUS_O   = s_q.grp_stat;
  assign GPIO_STATUS_O  = s_q.gpio_stat;
  assign BTN_MULTI_O    = s_q.btn_multi;
  assign GRP_MULTI_O    = s_q.grp_multi;
  assign LID_EVENT_O    = s_q.lid_stat;
  assign LID_NOISE_O    = s_q.lid_noise;
  assign NEW_SLEEP_CH_O = s_q.new_sleep;

  // Checks on the block's own outputs
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_sleep_write;
    REG_WR_I && REG_ADDR_I == OFS_SLEEP_SEL && SLEEP_I;
  endsequence

  sequence s_group_awake_event;
    !SLEEP_I && (|GRP_EVENT_I) && s_q.touch_en[GRP_IRQ_BIT] &&
    !(REG_WR_I && REG_ADDR_I == OFS_TOUCH_EN);
  endsequence

  a_grp_irq_gate: assert property (
    s_group_awake_event |=> ALERT_O && (|GRP_STATUS_O))
    else $error("group event did not raise alert");

  // Alert lags an enable change one cycle, so only judge stable enables
  a_btn_irq_gate: assert property (
    (|(BTN_STATUS_O & s_q.touch_en[6:0])) && $stable(s_q.touch_en)
    |-> ALERT_O)
    else $error("enabled button status without alert");

  a_gpio_irq_gate: assert property (
    (|(GPIO_SET_I & s_q.gpio_en)) &&
    !(REG_WR_I && REG_ADDR_I == OFS_GPIO_EN) |=> ALERT_O)
    else $error("enabled gpio event without alert");

  a_sleep_btn_mask: assert property (
    SLEEP_I && !s_q.sleep_sel[0] |=> !BTN_ACCEPT_O[0])
    else $error("unselected button sampled in sleep");

  a_sleep_grp_mask: assert property (
    SLEEP_I && !s_q.sleep_sel[GRP_SLEEP_BIT] && GRP_STATUS_O == 4'h0
    |=> GRP_STATUS_O == 4'h0)
    else $error("group status set while group asleep");

  a_sleep_new_ch: assert property (
    s_sleep_write |=>
    NEW_SLEEP_CH_O == ($past(REG_WDATA_I) & ~$past(s_q.sleep_sel)))
    else $error("new sleep channels misreported");

  a_block_limit: assert property (
    s_q.mt_cfg[BLOCK_EN_BIT] |=>
    $countones(BTN_ACCEPT_O) <=
    tec_btn_limit($past(s_q.mt_cfg[BTN_LIM_LSB+:2])))
    else $error("accepted touches exceed limit");

  a_btn_multi: assert property (
    !SLEEP_I |=> BTN_MULTI_O == ($countones($past(BTN_TOUCH_I)) >
    tec_btn_limit($past(s_q.mt_cfg[BTN_LIM_LSB+:2]))))
    else $error("button multi-touch flag wrong");

  a_grp_multi: assert property (
    !SLEEP_I |=> GRP_MULTI_O == ($countones($past(GRP_TOUCH_I)) >
    tec_grp_limit($past(s_q.mt_cfg[GRP_LIM_LSB+:2]))))
    else $error("group multi-touch flag wrong");

  a_lid_off: assert property (
    !s_q.lid_cfg[LID_EN_BIT] && !LID_EVENT_O ##1
    !s_q.lid_cfg[LID_EN_BIT] |-> !LID_EVENT_O && LID_NOISE_O == 14'h0000)
    else $error("lid event while lid detection disabled");

  a_lid_count: assert property (
    s_q.lid_cfg[LID_EN_BIT] && !s_q.lid_cfg[EXACT_BIT] &&
    (|LID_PATTERN_I) && $countones(LID_STATUS_I[6:0]) >=
    $countones(LID_PATTERN_I[6:0]) |=> LID_EVENT_O)
    else $error("count-mode lid closure missed");

  a_lid_exact: assert property (
    s_q.lid_cfg[LID_EN_BIT] && s_q.lid_cfg[EXACT_BIT] &&
    (|LID_PATTERN_I) &&
    (LID_STATUS_I & LID_PATTERN_I) == LID_PATTERN_I |=> LID_EVENT_O)
    else $error("exact-mode lid closure missed");

  a_lid_alert: assert property (
    LID_EVENT_O && s_q.lid_cfg[LID_IRQ_BIT] && $stable(s_q.lid_cfg)
    |-> ALERT_O)
    else $error("lid event with alert enabled but no alert");

  a_alert_quiet: assert property (
    BTN_STATUS_O == 7'h00 && GRP_STATUS_O == 4'h0 &&
    GPIO_STATUS_O == 8'h00 && !LID_EVENT_O |-> !ALERT_O)
    else $error("alert without any status");

  // Negative gates, stickiness and the sleep paths
  a_btn_sticky: assert property (
    !STATUS_CLR_I |=>
    (BTN_STATUS_O & $past(BTN_STATUS_O)) == $past(BTN_STATUS_O))
    else $error("button status lost without a clear");

  a_clr_set_wins: assert property (
    STATUS_CLR_I && (|GPIO_SET_I) |=>
    (GPIO_STATUS_O & $past(GPIO_SET_I)) == $past(GPIO_SET_I))
    else $error("gpio set lost to a same-cycle clear");

  a_grp_irq_off: assert property (
    !s_q.touch_en[GRP_IRQ_BIT] && $stable(s_q.touch_en) &&
    BTN_STATUS_O == 7'h00 && GPIO_STATUS_O == 8'h00 && !LID_EVENT_O
    |-> !ALERT_O)
    else $error("masked group status raised alert");

  a_lid_irq_off: assert property (
    !s_q.lid_cfg[LID_IRQ_BIT] && $stable(s_q.lid_cfg) &&
    BTN_STATUS_O == 7'h00 && GRP_STATUS_O == 4'h0 &&
    GPIO_STATUS_O == 8'h00 |-> !ALERT_O)
    else $error("lid event raised alert with alert disabled");

  a_exact_miss: assert property (
    s_q.lid_cfg[EXACT_BIT] && !LID_EVENT_O &&
    (LID_STATUS_I & LID_PATTERN_I) != LID_PATTERN_I |=> !LID_EVENT_O)
    else $error("exact-mode lid closure on partial match");

  a_new_ch_awake: assert property (
    !(REG_WR_I && SLEEP_I) |=> NEW_SLEEP_CH_O == 8'h00)
    else $error("new sleep channels flagged outside a sleep write");

  a_sleep_readback: assert property (
    REG_RD_I && !REG_WR_I && REG_ADDR_I == OFS_SLEEP_SEL |=>
    REG_RDATA_O == SAMPLE_MASK_O)
    else $error("sleep select read back wrong");

  // Blocking off passes every awake touch straight through
  a_block_off: assert property (
    !s_q.mt_cfg[BLOCK_EN_BIT] && !SLEEP_I |=>
    BTN_ACCEPT_O == $past(BTN_TOUCH_I))
    else $error("touch blocked with blocking disabled");

  sequence s_sleep_group_event;
    SLEEP_I && s_q.sleep_sel[GRP_SLEEP_BIT] && (|GRP_EVENT_I);
  endsequence

  a_sleep_grp_set: assert property (
    s_sleep_group_event |=>
    (GRP_STATUS_O & $past(GRP_EVENT_I)) == $past(GRP_EVENT_I))
    else $error("group event in sleep did not set status");

endmodule : tec_event_ctrl

// ### hw/tec_lid_cmp.sv
module tec_lid_cmp (
  // Lid compare link
  tec_lid_if.cmp lid
);
  import tec_pkg::*;

  logic [2:0] cnt_s1;
  logic [2:0] cnt_s2;
  logic [2:0] cnt_p1;
  logic [2:0] cnt_p2;
  logic       count_hit;
  logic       exact_hit;
  logic       pat_on;

  // Both lid compare methods, chosen by the exact-match flag
  always_comb begin
    cnt_s1    = tec_count7(lid.lid_status[6:0]);
    cnt_s2    = tec_count7(lid.lid_status[13:7]);
    cnt_p1    = tec_count7(lid.pattern[6:0]);
    cnt_p2    = tec_count7(lid.pattern[13:7]);
    // An all-zero pattern switches the detector off
    pat_on    = |lid.pattern;
    count_hit = (cnt_s1 >= cnt_p1) || (cnt_s2 >= cnt_p2) ||
                ({1'b0, cnt_s1} + {1'b0, cnt_s2} >=
                 {1'b0, cnt_p1} + {1'b0, cnt_p2});
    exact_hit = (lid.lid_status & lid.pattern) == lid.pattern;
    lid.hit   = pat_on && (lid.exact_match ? exact_hit : count_hit);
  end

endmodule : tec_lid_cmp

// ### inc/tec_lid_if.sv
interface tec_lid_if;
  logic [13:0] lid_status;
  logic [13:0] pattern;
  logic        exact_match;
  logic        hit;

  modport main (output lid_status, output pattern, output exact_match,
                input hit);
  modport cmp  (input lid_status, input pattern, input exact_match,
                output hit);
endinterface : tec_lid_if

// ### inc/tec_pkg.sv
package tec_pkg;

  // Sensor and pin counts
  localparam int NUM_BTN  = 7;
  localparam int NUM_GRP  = 7;
  localparam int NUM_GPIO = 8;
  localparam int NUM_LID  = 14;

  // Register offsets
  localparam logic [7:0] OFS_TOUCH_EN   = 8'h27;
  localparam logic [7:0] OFS_GPIO_EN    = 8'h28;
  localparam logic [7:0] OFS_SLEEP_SEL  = 8'h29;
  localparam logic [7:0] OFS_MT_CFG     = 8'h2a;
  localparam logic [7:0] OFS_LID_CFG    = 8'h2b;

  // Reset values
  localparam logic [7:0] RST_TOUCH_EN   = 8'hff;
  localparam logic [7:0] RST_GPIO_EN    = 8'h00;
  localparam logic [7:0] RST_SLEEP_SEL  = 8'h00;
  localparam logic [7:0] RST_MT_CFG     = 8'h82;
  localparam logic [7:0] RST_LID_CFG    = 8'h00;

  // Writable bits; reserved bits read as zero
  localparam logic [7:0] MT_WMASK       = 8'h8f;
  localparam logic [7:0] LID_WMASK      = 8'h83;

  // Field positions
  localparam int GRP_IRQ_BIT   = 7;
  localparam int GRP_SLEEP_BIT = 7;
  localparam int BLOCK_EN_BIT  = 7;
  localparam int BTN_LIM_LSB   = 2;
  localparam int GRP_LIM_LSB   = 0;
  localparam int LID_EN_BIT    = 7;
  localparam int EXACT_BIT     = 1;
  localparam int LID_IRQ_BIT   = 0;

  // Group event lanes: slide up, slide down, tap, press and hold
  localparam int GEV_UP   = 0;
  localparam int GEV_DOWN = 1;
  localparam int GEV_TAP  = 2;
  localparam int GEV_HOLD = 3;

  // Number of set bits in a 7-bit vector
  function automatic logic [2:0] tec_count7(input logic [6:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 7; i++) begin
      n = n + {2'b00, v[i]};
    end
    return n;
  endfunction : tec_count7

  // Button touch limit: code plus one
  function automatic logic [2:0] tec_btn_limit(input logic [1:0] c);
    return {1'b0, c} + 3'h1;
  endfunction : tec_btn_limit

  // Group touch limit: 2, 3, 4, then 1
  function automatic logic [2:0] tec_grp_limit(input logic [1:0] c);
    logic [2:0] l;
    case (c)
      2'b00:   l = 3'h2;
      2'b01:   l = 3'h3;
      2'b10:   l = 3'h4;
      default: l = 3'h1;
    endcase
    return l;
  endfunction : tec_grp_limit

endpackage : tec_pkg

// ### verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tec_pkg::*;
  logic        clk, rst_n, sleep, clr, wr, rd, alert, bmul, gmul, lid_ev;
  logic [7:0]  addr, wdata, rdata, gpio, smask, gpio_st, new_ch, v;
  logic [6:0]  btn, grp, accept, btn_st;
  logic [3:0]  gev, grp_st;
  logic [13:0] lid_st, lid_pat, noise, lid_noise;
  int          n_errors, checked;

  tec_event_ctrl i_tec_event_ctrl (.CLK_I(clk), .RST_N_I(rst_n),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .SLEEP_I(sleep), .BTN_TOUCH_I(btn),
    .GRP_TOUCH_I(grp), .GRP_EVENT_I(gev), .GPIO_SET_I(gpio),
    .LID_STATUS_I(lid_st), .LID_PATTERN_I(lid_pat), .NOISE_I(noise),
    .STATUS_CLR_I(clr), .ALERT_O(alert), .SAMPLE_MASK_O(smask),
    .BTN_ACCEPT_O(accept), .BTN_STATUS_O(btn_st), .GRP_STATUS_O(grp_st),
    .GPIO_STATUS_O(gpio_st), .BTN_MULTI_O(bmul), .GRP_MULTI_O(gmul),
    .LID_EVENT_O(lid_ev), .LID_NOISE_O(lid_noise), .NEW_SLEEP_CH_O(new_ch));

  tec_host_model i_tec_host_model (.clk_i(clk), .addr_o(addr), .wr_o(wr),
    .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata), .clr_o(clr));

  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  function automatic logic [6:0] ones(input int n);
    return 7'((1 << n) - 1);
  endfunction : ones

  // Inputs change at the edge; outputs judged two edges later
  task automatic apply(input logic [6:0] b, g, input logic [3:0] e,
                       input logic [7:0] p);
    @(posedge clk);
    btn <= b; grp <= g; gev <= e; gpio <= p;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : apply

  task automatic idle_clr();
    apply(7'h00, 7'h00, 4'h0, 8'h00);
    i_tec_host_model.clr();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : idle_clr

  task automatic reg_map();
    logic [7:0] rv [5];
    rv = '{8'hff, 8'h00, 8'h00, 8'h82, 8'h00};
    for (int i = 0; i < 5; i++) begin
      i_tec_host_model.rd(8'h27 + 8'(i), v);
      check("reset value", v, rv[i]);
    end
    check("sample mask", smask, 8'h00);
    i_tec_host_model.rd(8'h30, v);
    check("unmapped read", v, 8'h00);
    i_tec_host_model.wr(8'h2a, 8'hff);
    i_tec_host_model.rd(8'h2a, v);
    check("multi cfg bits", v, 8'h8f);
    i_tec_host_model.wr(8'h2b, 8'hff);
    i_tec_host_model.rd(8'h2b, v);
    check("lid cfg bits", v, 8'h83);
    i_tec_host_model.wr(8'h2a, 8'h82);
    i_tec_host_model.wr(8'h2b, 8'h00);
  endtask : reg_map

  task automatic button_alert();
    apply(7'h40, 7'h00, 4'h0, 8'h00);
    check("accept", accept, 7'h40);
    check("btn status", btn_st, 7'h40);
    check("alert", alert, 1'b1);
    idle_clr();
    check("alert cleared", alert, 1'b0);
    i_tec_host_model.wr(8'h27, 8'hbf);
    apply(7'h40, 7'h00, 4'h0, 8'h00);
    check("btn status", btn_st, 7'h40);
    check("masked alert", alert, 1'b0);
    apply(7'h01, 7'h00, 4'h0, 8'h00);
    check("alert", alert, 1'b1);
    idle_clr();
    i_tec_host_model.wr(8'h27, 8'h7f);
    apply(7'h00, 7'h00, 4'h4, 8'h00);
    check("grp status", grp_st, 4'h4);
    check("grp masked", alert, 1'b0);
    idle_clr();
    i_tec_host_model.wr(8'h27, 8'hff);
    apply(7'h00, 7'h00, 4'h8, 8'h00);
    check("grp alert", alert, 1'b1);
    idle_clr();
  endtask : button_alert

  task automatic gpio_alert();
    apply(7'h00, 7'h00, 4'h0, 8'h80);
    check("gpio status", gpio_st, 8'h80);
    check("gpio default", alert, 1'b0);
    idle_clr();
    i_tec_host_model.wr(8'h28, 8'h80);
    apply(7'h00, 7'h00, 4'h0, 8'h01);
    check("gpio masked", alert, 1'b0);
    apply(7'h00, 7'h00, 4'h0, 8'h80);
    check("gpio status", gpio_st, 8'h81);
    check("gpio alert", alert, 1'b1);
    idle_clr();
    i_tec_host_model.wr(8'h28, 8'h00);
  endtask : gpio_alert

  task automatic sleep_sampling();
    @(posedge clk);
    sleep <= 1'b1;
    apply(7'h01, 7'h00, 4'h4, 8'h00);
    check("sleep btn", btn_st, 7'h00);
    check("sleep grp", grp_st, 4'h0);
    i_tec_host_model.wr(8'h29, 8'h81);
    @(negedge clk);
    check("new channels", new_ch, 8'h81);
    check("sample mask", smask, 8'h81);
    @(negedge clk);
    check("new ch pulse", new_ch, 8'h00);
    repeat (2) @(negedge clk);
    check("sleep btn", btn_st, 7'h01);
    check("sleep grp", grp_st, 4'h4);
    check("sleep alert", alert, 1'b1);
    idle_clr();
    @(posedge clk);
    sleep <= 1'b0;
    i_tec_host_model.wr(8'h29, 8'h00);
  endtask : sleep_sampling

  task automatic multi_touch();
    int gl [4];
    gl = '{2, 3, 4, 1};
    for (int c = 0; c < 4; c++) begin
      apply(7'h00, 7'h00, 4'h0, 8'h00);
      i_tec_host_model.wr(8'h2a, 8'h80 | 8'(c * 5));
      apply(ones(c + 1), ones(gl[c]), 4'h0, 8'h00);
      check("btn at limit", bmul, 1'b0);
      check("grp at limit", gmul, 1'b0);
      apply(ones(c + 2), ones(gl[c] + 1), 4'h0, 8'h00);
      check("btn over", bmul, 1'b1);
      check("grp over", gmul, 1'b1);
      check("blocked", accept, ones(c + 1));
    end
    apply(7'h00, 7'h00, 4'h0, 8'h00);
    i_tec_host_model.wr(8'h2a, 8'h80);
    apply(7'h02, 7'h00, 4'h0, 8'h00);
    apply(7'h03, 7'h00, 4'h0, 8'h00);
    check("held kept", accept, 7'h02);
    i_tec_host_model.wr(8'h2a, 8'h0c);
    apply(7'h7f, 7'h00, 4'h0, 8'h00);
    check("no blocking", accept, 7'h7f);
    check("btn over", bmul, 1'b1);
    idle_clr();
    i_tec_host_model.wr(8'h2a, 8'h82);
  endtask : multi_touch

  task automatic lid_case(input logic [7:0] cfg, input logic [13:0] s, p,
                          input logic ev, al);
    @(posedge clk);
    lid_st  <= 14'h0000;
    lid_pat <= 14'h0000;
    i_tec_host_model.clr();
    i_tec_host_model.wr(8'h2b, cfg);
    @(posedge clk);
    lid_st  <= s;
    lid_pat <= p;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("lid event", lid_ev, ev);
    check("lid alert", alert, al);
    check("lid noise", lid_noise, cfg[7] ? 14'h0005 : 14'h0000);
  endtask : lid_case

  // Reset, then each scenario in turn
  initial begin
    rst_n = 1'b0; sleep = 1'b0; btn = '0; grp = '0; gev = '0; gpio = '0;
    lid_st = '0; lid_pat = '0; noise = 14'h0005;
    n_errors = 0; checked = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    reg_map();
    button_alert();
    gpio_alert();
    sleep_sampling();
    multi_touch();
    lid_case(8'h00, 14'h0070, 14'h0007, 1'b0, 1'b0);
    lid_case(8'h80, 14'h0070, 14'h0007, 1'b1, 1'b0);
    lid_case(8'h82, 14'h0070, 14'h0007, 1'b0, 1'b0);
    lid_case(8'h82, 14'h0077, 14'h0007, 1'b1, 1'b0);
    lid_case(8'h83, 14'h0007, 14'h0007, 1'b1, 1'b1);
    lid_case(8'h81, 14'h0180, 14'h0603, 1'b1, 1'b1);
    lid_case(8'h81, 14'h0081, 14'h0183, 1'b0, 1'b0);
    results();
  end

  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule : tb

// ### verification/tec_host_model.sv
// Host side: drives the register port and the status clear pulse
module tec_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output      logic [7:0] addr_o,
  output      logic       wr_o,
  output      logic [7:0] wdata_o,
  output      logic       rd_o,
  input  wire logic [7:0] rdata_i,
  // Status clear
  output      logic       clr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
    rd_o    = 1'b0;
    clr_o   = 1'b0;
  end

  // Released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr

  // Read data stands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd

  // One-cycle clear of all sticky status
  task automatic clr();
    @(posedge clk_i);
    clr_o <= 1'b1;
    @(posedge clk_i);
    clr_o <= 1'b0;
  endtask : clr
endmodule : tec_host_model
